/* rtl/acc_comparator_control.sv */
// Control, status and interrupt logic around an analog voltage comparator
// Contract
// RULE1 - Pad enable bit one drives comparator output to pin, zero keeps off
// RULE2 - Edge field 5:4: 0 any, 2 falling, 3 rising, 1 reserved
// RULE3 - Control bit 3 selects low current operation of the comparator
// RULE4 - Hysteresis field 2:1: off, 10, 25 or 50 millivolts
// RULE5 - Control bit 0 enables the comparator, zero disables it
// RULE6 - Select bit 7 inverts output for pad, state and edges
// RULE7 - Plus select code 0 connects plus pin zero, code 1 nothing
// RULE8 - Minus field 1:0: pin zero, reference, converter; 1 reserved
// RULE9 - Interrupt enable bit 0 permits or masks the request
// RULE10 - Status bit 4 shows synchronised output, three cycles late
// RULE11 - Status bit 0 flag clears on writing one, zero leaves it
// RULE12 - Request high while enable and flag set, until flag clears
// RULE13 - Keep-run bit: in standby, events and pad run, flags frozen
// RULE14 - Raw output is one when plus input exceeds minus input
// RULE15 - Edges found on synchronised output, one flag set per edge
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`include "acc_params.svh"

module acc_comparator_control
  import acc_pkg::*;
(
  input  wire logic      i_core_clk,
  input  wire logic      i_srst,
  input  wire logic      i_ce,
  input  wire acc_addr_t i_addr,
  input  wire acc_byte_t i_wdata,
  input  wire logic      i_wr,
  input  wire logic      i_rd,
  output acc_byte_t      o_rdata,
  input  wire logic      i_cmp_raw,
  input  wire logic      i_standby,
  output logic           o_cmp_enable,
  output logic           o_low_current,
  output acc_code_t      o_hyst_level,
  output logic           o_plus_connect,
  output acc_code_t      o_minus_sel,
  output logic           o_minus_valid,
  output logic           o_pad_out,
  output logic           o_pad_oe,
  output logic           o_event,
  output logic           o_irq
);

  function automatic logic edge_match(input acc_code_t sel,
                                      input logic      prev,
                                      input logic      cur);
    logic hit;
    hit = 1'b0;
    case (sel)
      `ACC_EDGE_ANY:  hit = prev ^ cur;
      `ACC_EDGE_FALL: hit = prev & ~cur;
      `ACC_EDGE_RISE: hit = ~prev & cur;
      default:        hit = 1'b0;
    endcase
    return hit;
  endfunction

  acc_byte_t control_reg;
  acc_byte_t control_next;
  acc_byte_t insel_reg;
  acc_byte_t insel_next;
  acc_byte_t irqen_reg;
  acc_byte_t irqen_next;
  logic      flag_reg;
  logic      flag_next;
  logic      sync1_reg;
  logic      sync1_next;
  logic      sync2_reg;
  logic      sync2_next;
  logic      state_reg;
  logic      state_next;
  logic      pad_reg;
  logic      pad_next;
  acc_byte_t rdata_reg;
  acc_byte_t rdata_next;

  acc_code_t edge_sel;
  logic      pad_en;
  logic      keep_run;
  logic      invert;
  logic      halted;
  logic      active;
  logic      flag_upd;
  logic      cmp_out;
  logic      edge_hit;
  logic      w1c_hit;

  assign edge_sel = control_reg[`ACC_CTL_EDGE_LO +: 2];
  assign pad_en   = control_reg[`ACC_CTL_PAD];
  assign keep_run = control_reg[`ACC_CTL_KEEP_RUN];
  assign invert   = insel_reg[`ACC_SEL_INVERT];

  // Standby without keep-run halts the comparator entirely
  assign halted   = i_standby & ~keep_run;                      // RULE13
  assign active   = control_reg[`ACC_CTL_ENABLE] & ~halted;     // RULE5
  assign flag_upd = active & ~i_standby;                        // RULE13

  // Raw core output is plus above minus; inversion comes after it
  assign cmp_out  = i_cmp_raw ^ invert;                         // RULE14 RULE6

  assign edge_hit = flag_upd & edge_match(edge_sel, state_reg,
                                          sync2_reg);           // RULE15 RULE2
  assign w1c_hit  = i_wr & (i_addr == `ACC_OFS_STATUS)
                  & i_wdata[`ACC_STAT_FLAG];

  // Register file and read port
  always_comb begin
    control_next = control_reg;
    insel_next   = insel_reg;
    irqen_next   = irqen_reg;
    rdata_next   = 8'h00;
    if (i_wr) begin
      case (i_addr)
        `ACC_OFS_CONTROL:   control_next = i_wdata & `ACC_WMASK_CONTROL;
        `ACC_OFS_INPUT_SEL: insel_next   = i_wdata & `ACC_WMASK_SEL;
        `ACC_OFS_IRQ_EN:    irqen_next   = i_wdata & `ACC_WMASK_IRQ;
        default:            control_next = control_reg;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        `ACC_OFS_CONTROL:   rdata_next = control_reg;
        `ACC_OFS_INPUT_SEL: rdata_next = insel_reg;
        `ACC_OFS_IRQ_EN:    rdata_next = irqen_reg;
        `ACC_OFS_STATUS: begin
          rdata_next[`ACC_STAT_FLAG]  = flag_reg;
          rdata_next[`ACC_STAT_STATE] = state_reg;              // RULE10
        end
        default:            rdata_next = 8'h00;
      endcase
    end
  end

  // Synchroniser, edge flag and pad drive
  always_comb begin
    sync1_next = cmp_out;
    sync2_next = sync1_reg;
    state_next = sync2_reg;                                     // RULE10
    pad_next   = cmp_out & pad_en & active;                     // RULE1
    flag_next  = flag_reg;
    if (w1c_hit) begin
      flag_next = 1'b0;                                         // RULE11
    end
    // A new edge wins over a clear in the same cycle
    if (edge_hit) begin
      flag_next = 1'b1;                                         // RULE15
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      control_reg <= `ACC_RST_CONTROL;
      insel_reg   <= `ACC_RST_INPUT_SEL;
      irqen_reg   <= `ACC_RST_IRQ_EN;
      flag_reg    <= 1'b0;
      sync1_reg   <= 1'b0;
      sync2_reg   <= 1'b0;
      state_reg   <= 1'b0;
      pad_reg     <= 1'b0;
      rdata_reg   <= 8'h00;
    end else if (i_ce) begin
      control_reg <= control_next;
      insel_reg   <= insel_next;
      irqen_reg   <= irqen_next;
      flag_reg    <= flag_next;
      sync1_reg   <= sync1_next;
      sync2_reg   <= sync2_next;
      state_reg   <= state_next;
      pad_reg     <= pad_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign o_rdata        = rdata_reg;
  assign o_cmp_enable   = active;                               // RULE5
  assign o_low_current  = control_reg[`ACC_CTL_LOW_CUR];        // RULE3
  assign o_hyst_level   = control_reg[`ACC_CTL_HYST_LO +: 2];   // RULE4
  assign o_plus_connect = insel_reg[`ACC_SEL_PLUS]
                          == `ACC_PLUS_PIN0;                    // RULE7
  assign o_minus_sel    = insel_reg[`ACC_SEL_MINUS_LO +: 2];    // RULE8
  assign o_minus_valid  = o_minus_sel != `ACC_MINUS_RSVD;       // RULE8
  assign o_pad_out      = pad_reg;
  assign o_pad_oe       = pad_en & active;                      // RULE1
  assign o_event        = state_reg & active;                   // RULE13
  assign o_irq          = flag_reg & irqen_reg[`ACC_IRQ_BIT];   // RULE12 RULE9

  property p_pad_follow;
    @(posedge i_core_clk) disable iff (i_srst)
      (i_ce && o_pad_oe && !i_wr) |=> o_pad_out == $past(cmp_out);
  endproperty
  a_pad_follow: assert property (p_pad_follow) // RULE1
    else $error("pad does not follow comparator output");

  property p_pad_off;
    @(posedge i_core_clk) disable iff (i_srst)
      (i_ce && !pad_en) |=> !o_pad_out;
  endproperty
  a_pad_off: assert property (p_pad_off) // RULE1
    else $error("pad carries output while disabled");

  property p_fall_only;
    @(posedge i_core_clk) disable iff (i_srst)
      (i_ce && flag_upd && edge_sel == `ACC_EDGE_FALL
       && !state_reg && sync2_reg && !flag_reg) |=> !flag_reg;
  endproperty
  a_fall_only: assert property (p_fall_only) // RULE2
    else $error("rising edge set flag in falling mode");

  property p_rise_sets;
    @(posedge i_core_clk) disable iff (i_srst)
      (i_ce && flag_upd && edge_sel == `ACC_EDGE_RISE
       && !state_reg && sync2_reg) |=> flag_reg;
  endproperty
  a_rise_sets: assert property (p_rise_sets) // RULE2
    else $error("rising edge missed");

  property p_reserved_edge;
    @(posedge i_core_clk) disable iff (i_srst)
      (i_ce && edge_sel == `ACC_EDGE_RSVD && !flag_reg) |=> !flag_reg;
  endproperty
  a_reserved_edge: assert property (p_reserved_edge) // RULE2
    else $error("reserved edge code set flag");

  property p_ctl_write;
    @(posedge i_core_clk) disable iff (i_srst)
      (i_ce && i_wr && i_addr == `ACC_OFS_CONTROL && !i_standby)
      |=> (o_low_current == $past(i_wdata[3]))
       && (o_hyst_level == $past(i_wdata[2:1]))
       && (o_cmp_enable == ($past(i_wdata[0])
           && !(i_standby && !$past(i_wdata[`ACC_CTL_KEEP_RUN]))));
  endproperty
  a_ctl_write: assert property (p_ctl_write) // RULE3 RULE4 RULE5
    else $error("control write not applied");

  sequence s_ce3;
    i_ce [*3];
  endsequence

  property p_state_delay;
    @(posedge i_core_clk) disable iff (i_srst)
      s_ce3 |=> state_reg == $past(cmp_out, 3);
  endproperty
  a_state_delay: assert property (p_state_delay) // RULE10 RULE6
    else $error("state not three cycles after output");

  property p_status_read;
    @(posedge i_core_clk) disable iff (i_srst)
      (i_ce && i_rd && i_addr == `ACC_OFS_STATUS)
      |=> o_rdata == {3'h0, $past(state_reg), 3'h0, $past(flag_reg)};
  endproperty
  a_status_read: assert property (p_status_read) // RULE10 RULE11
    else $error("status read wrong");

  property p_w1c_zero;
    @(posedge i_core_clk) disable iff (i_srst)
      (i_ce && flag_reg && !w1c_hit) |=> flag_reg;
  endproperty
  a_w1c_zero: assert property (p_w1c_zero) // RULE11
    else $error("flag lost without a clearing write");

  property p_w1c_one;
    @(posedge i_core_clk) disable iff (i_srst)
      (i_ce && w1c_hit && !edge_hit) |=> !flag_reg;
  endproperty
  a_w1c_one: assert property (p_w1c_one) // RULE11
    else $error("flag not cleared by writing one");

  property p_irq_level;
    @(posedge i_core_clk) disable iff (i_srst)
      (i_ce && edge_hit && irqen_reg[0] && !i_wr) |=> o_irq [*1];
  endproperty
  a_irq_level: assert property (p_irq_level) // RULE12 RULE9
    else $error("request missing after flagged edge");

  property p_irq_masked;
    @(posedge i_core_clk) disable iff (i_srst)
      !irqen_reg[0] |-> !o_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) // RULE9
    else $error("request while masked");

  property p_standby_frozen;
    @(posedge i_core_clk) disable iff (i_srst)
      (i_ce && i_standby && !flag_reg) |=> !flag_reg;
  endproperty
  a_standby_frozen: assert property (p_standby_frozen) // RULE13
    else $error("flag set in standby");

  property p_minus_rsvd;
    @(posedge i_core_clk) disable iff (i_srst)
      (o_minus_sel == `ACC_MINUS_RSVD) |-> !o_minus_valid;
  endproperty
  a_minus_rsvd: assert property (p_minus_rsvd) // RULE8
    else $error("reserved minus code marked valid");

  property p_one_set;
    @(posedge i_core_clk) disable iff (i_srst)
      (i_ce && edge_hit) |=> (state_reg == $past(sync2_reg));
  endproperty
  a_one_set: assert property (p_one_set) // RULE15
    else $error("edge seen twice");

endmodule

/* rtl/acc_params.svh */
// Offsets, field positions, reset values and timing of the comparator control
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

`define ACC_OFS_CONTROL   3'h0
`define ACC_OFS_INPUT_SEL 3'h2
`define ACC_OFS_IRQ_EN    3'h6
`define ACC_OFS_STATUS    3'h7

`define ACC_CTL_ENABLE    0
`define ACC_CTL_HYST_LO   1
`define ACC_CTL_LOW_CUR   3
`define ACC_CTL_EDGE_LO   4
`define ACC_CTL_PAD       6
`define ACC_CTL_KEEP_RUN  7
`define ACC_SEL_MINUS_LO  0
`define ACC_SEL_PLUS      3
`define ACC_SEL_INVERT    7
`define ACC_IRQ_BIT       0
`define ACC_STAT_FLAG     0
`define ACC_STAT_STATE    4

`define ACC_EDGE_ANY      2'h0
`define ACC_EDGE_RSVD     2'h1
`define ACC_EDGE_FALL     2'h2
`define ACC_EDGE_RISE     2'h3
`define ACC_MINUS_RSVD    2'h1
`define ACC_PLUS_PIN0     1'h0

`define ACC_RST_CONTROL   8'h00
`define ACC_RST_INPUT_SEL 8'h00
`define ACC_RST_IRQ_EN    8'h00
`define ACC_WMASK_CONTROL 8'hFF
`define ACC_WMASK_SEL     8'h8B
`define ACC_WMASK_IRQ     8'h01

`define ACC_SYNC_CYCLES   3

`endif

/* rtl/acc_pkg.sv */
// Types shared by the comparator control logic
package acc_pkg;
  typedef logic [7:0] acc_byte_t;
  typedef logic [2:0] acc_addr_t;
  typedef logic [1:0] acc_code_t;
endpackage

/* tb/acc_analog_model.sv */
// Behavioural analog comparator core facing the control logic
`timescale 1ns/100ps
module acc_analog_model
  import acc_pkg::*;
#(
  parameter int REF_MV = 500,
  parameter int DAC_MV = 1000
) (
  input  wire logic      i_enable,
  input  wire logic      i_plus_connect,
  input  wire acc_code_t i_minus_sel,
  input  wire logic      i_minus_valid,
  input  int             i_plus_mv,
  input  int             i_minus_mv,
  output logic           o_cmp_raw
);
  int minus_mv;
  always_comb begin
    case (i_minus_sel)
      2'h2: minus_mv = REF_MV;
      2'h3: minus_mv = DAC_MV;
      default: minus_mv = i_minus_mv;
    endcase
    // An idle or unrouted core reads low
    o_cmp_raw = i_enable && i_plus_connect && i_minus_valid
                && (i_plus_mv > minus_mv);
  end
endmodule

/* tb/acc_comparator_control_bench.sv */
// Self-checking bench for the comparator control logic
`timescale 1ns/100ps
`include "acc_params.svh"
module acc_comparator_control_bench
  import acc_pkg::*;
;
  logic      clk, srst, bus_wr, bus_rd, raw, standby, ce;
  logic      cmp_en, low_cur, plus_con, minus_val;
  logic      pad_out, pad_oe, evt, irq;
  acc_addr_t addr;
  acc_byte_t wdata, rdata;
  acc_code_t hyst, minus_sel;
  int        plus_mv, fails, cmp_count;

  acc_comparator_control acc_comparator_control_inst (
    .i_core_clk(clk), .i_srst(srst), .i_ce(ce), .i_addr(addr),
    .i_wdata(wdata), .i_wr(bus_wr), .i_rd(bus_rd), .o_rdata(rdata),
    .i_cmp_raw(raw), .i_standby(standby), .o_cmp_enable(cmp_en),
    .o_low_current(low_cur), .o_hyst_level(hyst),
    .o_plus_connect(plus_con), .o_minus_sel(minus_sel),
    .o_minus_valid(minus_val), .o_pad_out(pad_out), .o_pad_oe(pad_oe),
    .o_event(evt), .o_irq(irq));

  acc_analog_model acc_analog_model_inst (
    .i_enable(cmp_en), .i_plus_connect(plus_con),
    .i_minus_sel(minus_sel), .i_minus_valid(minus_val),
    .i_plus_mv(plus_mv), .i_minus_mv(900), .o_cmp_raw(raw));

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input acc_byte_t got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic set_in(input int mv);
    @(posedge clk);
    plus_mv <= mv;
  endtask

  task automatic reg_wr(input acc_addr_t a, input acc_byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  task automatic reg_rd(input acc_addr_t a, input acc_byte_t e,
                        input string what);
    @(posedge clk);
    addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    @(negedge clk);
    check(rdata, e, what);
  endtask

  task automatic t_reset();
    for (int a = 0; a < 8; a++) reg_rd(3'(a), 8'h00, "reset");
    check(8'({plus_con, minus_val, irq}), 8'h06, "reset pins");
  endtask

  task automatic t_control();
    for (int h = 0; h < 4; h++) begin
      reg_wr(`ACC_OFS_CONTROL, 8'(h * 2 + 9));
      reg_rd(`ACC_OFS_CONTROL, 8'(h * 2 + 9), "ctl");
      check(8'({hyst, low_cur, cmp_en}), 8'(h * 4 + 3), "hyst");
    end
    reg_wr(`ACC_OFS_CONTROL, 8'h00);
    tick(1);
    check(8'({hyst, low_cur, cmp_en}), 8'h00, "off");
  endtask

  task automatic t_select();
    reg_wr(`ACC_OFS_CONTROL, 8'h01);
    set_in(700);
    for (int m = 0; m < 4; m++) begin
      reg_wr(`ACC_OFS_INPUT_SEL, 8'(m));
      tick(5);
      check(8'({minus_sel, minus_val}), 8'(m * 2 + (m != 1)), "mx");
      check(8'(evt), 8'(m == 2), "route");
    end
    reg_wr(`ACC_OFS_INPUT_SEL, 8'h0A);
    tick(5);
    check(8'({plus_con, evt}), 8'h00, "plus");
    reg_wr(`ACC_OFS_INPUT_SEL, 8'hFF);
    reg_rd(`ACC_OFS_INPUT_SEL, 8'h8B, "sel mask");
    reg_wr(`ACC_OFS_INPUT_SEL, 8'h00);
  endtask

  task automatic t_delay();
    set_in(0);
    tick(5);
    set_in(1000);
    tick(2);
    check(8'(evt), 8'h00, "early");
    tick(1);
    check(8'(evt), 8'h01, "state");
  endtask

  task automatic t_edges();
    logic f;
    reg_wr(`ACC_OFS_IRQ_EN, 8'hFF);
    reg_rd(`ACC_OFS_IRQ_EN, 8'h01, "irq mask");
    for (int e = 0; e < 4; e++) begin
      reg_wr(`ACC_OFS_CONTROL, 8'(e * 16 + 1));
      set_in(0);
      tick(5);
      reg_wr(`ACC_OFS_STATUS, 8'h01);
      set_in(1000);
      tick(5);
      f = (e == 0 || e == 3);
      reg_rd(`ACC_OFS_STATUS, {7'h08, f}, "rise");
      check(8'(irq), 8'(f), "irq");
      reg_wr(`ACC_OFS_STATUS, 8'h00);
      reg_rd(`ACC_OFS_STATUS, {7'h08, f}, "keep");
      reg_wr(`ACC_OFS_STATUS, 8'h01);
      reg_rd(`ACC_OFS_STATUS, 8'h10, "clear");
      set_in(0);
      tick(5);
      f = (e == 0 || e == 2);
      reg_rd(`ACC_OFS_STATUS, {7'h00, f}, "fall");
      check(8'(irq), 8'(f), "irq");
      reg_wr(`ACC_OFS_STATUS, 8'h01);
    end
    reg_wr(`ACC_OFS_CONTROL, 8'h01);
    reg_wr(`ACC_OFS_IRQ_EN, 8'h00);
    set_in(1000);
    tick(5);
    check(8'(irq), 8'h00, "masked");
    reg_wr(`ACC_OFS_IRQ_EN, 8'h01);
    tick(1);
    check(8'(irq), 8'h01, "unmasked");
    reg_wr(`ACC_OFS_STATUS, 8'h01);
    tick(1);
    check(8'(irq), 8'h00, "irq drop");
  endtask

  task automatic t_invert();
    reg_wr(`ACC_OFS_CONTROL, 8'h41);
    reg_wr(`ACC_OFS_INPUT_SEL, 8'h80);
    set_in(0);
    tick(5);
    check(8'({evt, pad_oe, pad_out}), 8'h07, "invert");
    reg_wr(`ACC_OFS_CONTROL, 8'h01);
    tick(2);
    check(8'({evt, pad_oe, pad_out}), 8'h04, "pad off");
    reg_wr(`ACC_OFS_INPUT_SEL, 8'h00);
  endtask

  task automatic t_standby();
    tick(3);
    reg_wr(`ACC_OFS_CONTROL, 8'hC1);
    reg_wr(`ACC_OFS_STATUS, 8'h01);
    standby <= 1'b1;
    set_in(1000);
    tick(5);
    check(8'({evt, pad_out, irq}), 8'h06, "standby run");
    reg_wr(`ACC_OFS_CONTROL, 8'h41);
    tick(1);
    check(8'({cmp_en, pad_oe}), 8'h00, "halted");
    @(posedge clk);
    standby <= 1'b0;
    tick(1);
    check(8'(cmp_en), 8'h01, "wake");
  endtask

  // Clock enable low must hold every register, bus writes included
  task automatic t_freeze();
    reg_wr(`ACC_OFS_CONTROL, 8'h01);
    set_in(0);
    tick(5);
    @(posedge clk);
    ce <= 1'b0;
    reg_wr(`ACC_OFS_CONTROL, 8'h41);
    set_in(1000);
    tick(5);
    check(8'({evt, pad_oe}), 8'h00, "frozen");
    @(posedge clk);
    ce <= 1'b1;
    tick(2);
    check(8'(evt), 8'h00, "thaw early");
    tick(1);
    check(8'(evt), 8'h01, "thaw");
    reg_rd(`ACC_OFS_CONTROL, 8'h01, "dropped write");
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Over ten times the few hundred cycles the sequence needs
  initial begin
    #125000;
    fails++;
    print_verdict();
  end

  initial begin
    srst = 1'b1;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    standby = 1'b0;
    ce = 1'b1;
    addr = 3'h0;
    wdata = 8'h00;
    plus_mv = 0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_control();
    t_select();
    t_delay();
    t_edges();
    t_invert();
    t_standby();
    t_freeze();
    print_verdict();
  end
endmodule
